// File: stsq_pkg.sv
// stsq_pkg: shared constants and carrier types of the three-phase step sequencer.
// assumes a single 250 MHz core clock; every cycle count below is derived from it.
package stsq_pkg;

    // ----------------------------------------------------------------
    // timing
    // ----------------------------------------------------------------
    localparam int CLK_MHZ = 250;
    localparam int CP_START_US = 1700; // 1.7 ms charge-pump start
    localparam int CP_START_CYC = CP_START_US * CLK_MHZ;
    localparam int MIN_PULSE_US = 10;
    // half the least legal pulse: anything shorter is a glitch
    localparam int FILT_CYC = MIN_PULSE_US * CLK_MHZ / 2;
    localparam int MON_PULSE_US = 1;
    localparam int MON_CYC = MON_PULSE_US * CLK_MHZ;

    // ----------------------------------------------------------------
    // phase position and current levels
    // ----------------------------------------------------------------
    localparam logic [6:0] POS_STEPS = 7'h30; // 48 sub-steps per cycle
    localparam logic [5:0] POS_RESET = 6'h00;
    localparam logic [5:0] OFS_U = 6'h00;
    localparam logic [5:0] OFS_V = 6'h20; // -120 degrees
    localparam logic [5:0] OFS_W = 6'h10; // +120 degrees
    localparam logic [7:0] PCT_FULL = 8'h64;
    localparam logic [7:0] RECT_THR = 8'h32;

    // ----------------------------------------------------------------
    // filtered pin vector indices
    // ----------------------------------------------------------------
    localparam int IX_STEP = 0;
    localparam int IX_MODE_A = 1;
    localparam int IX_MODE_B = 2;
    localparam int IX_EDGE = 3;
    localparam int IX_RECT_N = 4;
    localparam int IX_FREEZE_N = 5;
    localparam int IX_DIR = 6;
    localparam int IX_OE = 7;
    localparam int IX_RESET_N = 8;
    localparam int N_PINS = 9;

    // ----------------------------------------------------------------
    // register map
    // ----------------------------------------------------------------
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_STATUS = 12'h004;
    localparam logic [11:0] ADDR_CYCLES = 12'h008;
    localparam logic CTRL_RESET = 1'b1;
    localparam int CTRL_SOFT_EN_BIT = 0;
    localparam int ST_POS_LSB = 0;
    localparam int ST_DIR_BIT = 8;
    localparam int ST_CP_BIT = 9;
    localparam int ST_FREEZE_BIT = 10;
    localparam int ST_VALID_BIT = 11;
    localparam int ST_GATE_BIT = 12;

    typedef struct packed {
        logic [5:0] inc;
        logic both;
        logic rect;
        logic valid;
    } stsq_mode_t;

    typedef struct packed {
        logic s1;
        logic s2;
        logic [11:0] cnt;
        logic q;
    } stsq_filt_st_t;

    typedef struct packed {
        logic [5:0] pos;
        logic dir_lat;
        logic step_d;
        logic resume_wait;
        logic [19:0] cp_cnt;
        logic cp_done;
        logic cp_run;
        logic [7:0] mon_cnt;
        logic mon;
        logic gate;
        logic [7:0] ph_u;
        logic [7:0] ph_v;
        logic [7:0] ph_w;
        logic [15:0] cyc_cnt;
        logic soft_en;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } stsq_top_st_t;

endpackage

// File: stsq_in_filter.sv
// stsq_in_filter: two-flop synchroniser plus glitch filter for one pin.
// assumes the pin is asynchronous to the clock and pulled to INIT when idle.
`timescale 1ns/100ps
module stsq_in_filter #(
    parameter logic INIT = 1'b1
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic pin_in,
    output logic level_out
);
    stsq_pkg::stsq_filt_st_t s_reg;
    stsq_pkg::stsq_filt_st_t s_next;

    // new level accepted only after it stood for the whole filter time
    always_comb begin
        s_next = s_reg;
        s_next.s1 = pin_in;
        s_next.s2 = s_reg.s1;
        if (s_reg.s2 == s_reg.q) begin
            s_next.cnt = 12'h000;
        end else if (s_reg.cnt == 12'(stsq_pkg::FILT_CYC - 1)) begin
            s_next.q = s_reg.s2;
            s_next.cnt = 12'h000;
        end else begin
            s_next.cnt = s_reg.cnt + 12'h001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_reg <= '{s1: INIT, s2: INIT, cnt: 12'h000, q: INIT};
        end else begin
            s_reg <= s_next;
        end
    end

    assign level_out = s_reg.q;
endmodule

// File: stsq_phase_lut.sv
// stsq_phase_lut: quasi-sine current level of one phase, in signed percent.
// assumes pos is below 48; OFS shifts the phase by multiples of 7.5 degrees.
`timescale 1ns/100ps
module stsq_phase_lut #(
    parameter logic [5:0] OFS = 6'h00
) (
    input wire logic [5:0] pos,
    input wire logic rect,
    output logic [7:0] pct
);
    // quarter wave, 7.5 degree steps, peak 100
    function automatic logic [7:0] quarter(input logic [3:0] k);
        logic [7:0] v;
        v = 8'h00;
        unique case (k)
            4'h0: v = 8'h00;
            4'h1: v = 8'h0D;
            4'h2: v = 8'h1A;
            4'h3: v = 8'h26;
            4'h4: v = 8'h32;
            4'h5: v = 8'h3D;
            4'h6: v = 8'h47;
            4'h7: v = 8'h4F;
            4'h8: v = 8'h57;
            4'h9: v = 8'h5C;
            4'hA: v = 8'h60;
            4'hB: v = 8'h62;
            default: v = 8'h64;
        endcase
        return v;
    endfunction

    logic [6:0] sum;
    logic [5:0] ang;
    logic [7:0] mag;
    logic neg;

    // fold the angle into one quadrant, then apply sign and rectangular cut
    always_comb begin
        sum = {1'b0, pos} + {1'b0, OFS};
        ang = (sum >= stsq_pkg::POS_STEPS) ? 6'(sum - stsq_pkg::POS_STEPS) : sum[5:0];
        neg = (ang >= 6'h18);
        if (ang < 6'h0C) begin
            mag = quarter(ang[3:0]);
        end else if (ang < 6'h18) begin
            mag = quarter(4'(6'h18 - ang));
        end else if (ang < 6'h24) begin
            mag = quarter(4'(ang - 6'h18));
        end else begin
            mag = quarter(4'(6'h30 - ang));
        end
        if (rect) begin
            mag = (mag >= stsq_pkg::RECT_THR) ? stsq_pkg::PCT_FULL : 8'h00;
        end
        pct = neg ? 8'(8'h00 - mag) : mag;
    end
endmodule

// File: stsq_sequencer.sv
// stsq_sequencer: control logic of a three-phase microstepping motor driver.
// assumes pins arrive asynchronously; APB is on CORE_CLK; RST is synchronous.
// Summary of operation
// - reset pin low stops the charge pump, so no gate can conduct
// - after reset release gates stay off 1.7 ms; step edges then ignored
// - reset position gives U zero, V minus 87, W plus 87 percent
// - in rectangular two-three mode reset gives V minus 100, W plus 100
// - edge-mode high: advance only on rising step edges
// - edge-mode low: advance on both step edges
// - four mode pins pick nine excitations of 6 to 48 counts per cycle
// - freeze low keeps currents and ignores step edges
// - after freeze release stepping resumes on next rising edge
// - direction high is clockwise; change takes effect on a rising edge
// - output-enable low forces all gate drives low
// - output-enable acts at once, independent of step edges
// - one monitor pulse per electrical cycle
//
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/100ps
module stsq_sequencer #(
    parameter int CP_START_CYC = stsq_pkg::CP_START_CYC
) (
    input wire logic CORE_CLK,
    input wire logic RST,
    input wire logic STEP_CLK,
    input wire logic MODE_A,
    input wire logic MODE_B,
    input wire logic EDGE_MODE,
    input wire logic RECT_CURRENT_SELECT_N,
    input wire logic FREEZE_N,
    input wire logic ROTATION_DIRECTION,
    input wire logic OUTPUT_ENABLE,
    input wire logic RESET_N,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [11:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic PREADY,
    output logic [31:0] PRDATA,
    output logic PSLVERR,
    output logic [7:0] PHASE_U,
    output logic [7:0] PHASE_V,
    output logic [7:0] PHASE_W,
    output logic GATE_EN,
    output logic CHARGE_PUMP_RUN,
    output logic CYCLE_MONITOR_PULSE
);
    // ----------------------------------------------------------------
    // pin conditioning
    // ----------------------------------------------------------------
    logic [stsq_pkg::N_PINS-1:0] pins;
    logic [stsq_pkg::N_PINS-1:0] f;

    assign pins = {RESET_N, OUTPUT_ENABLE, ROTATION_DIRECTION, FREEZE_N,
                   RECT_CURRENT_SELECT_N, EDGE_MODE, MODE_B, MODE_A, STEP_CLK};

    // step clock idles low; the others idle at their pull-up level
    genvar gi;
    generate
        for (gi = 0; gi < stsq_pkg::N_PINS; gi++) begin : g_pin
            stsq_in_filter #(
                .INIT((gi == stsq_pkg::IX_STEP) ? 1'b0 : 1'b1)
            ) u_filt (
                .clk(CORE_CLK),
                .rst(RST),
                .pin_in(pins[gi]),
                .level_out(f[gi])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // excitation decode
    // ----------------------------------------------------------------
    // inc is in 1/48 cycle units per counted edge; dual-edge halves it
    function automatic stsq_pkg::stsq_mode_t mode_decode(
        input logic a,
        input logic b,
        input logic c,
        input logic rect_n
    );
        stsq_pkg::stsq_mode_t m;
        m = '{inc: 6'h00, both: 1'b0, rect: 1'b0, valid: 1'b1};
        unique case ({a, b, c})
            3'b001: m.inc = 6'h08;
            3'b011: begin
                m.inc = 6'h04;
                m.rect = !rect_n;
            end
            3'b101: m.inc = 6'h02;
            3'b111: m.inc = 6'h01;
            3'b000: begin
                m.inc = 6'h04;
                m.both = 1'b1;
                m.rect = !rect_n;
            end
            3'b010: begin
                m.inc = 6'h02;
                m.both = 1'b1;
            end
            3'b100: begin
                m.inc = 6'h01;
                m.both = 1'b1;
            end
            default: m.valid = 1'b0; // unlisted combination holds still
        endcase
        return m;
    endfunction

    stsq_pkg::stsq_mode_t md;

    assign md = mode_decode(f[stsq_pkg::IX_MODE_A], f[stsq_pkg::IX_MODE_B],
                            f[stsq_pkg::IX_EDGE], f[stsq_pkg::IX_RECT_N]);

    // ----------------------------------------------------------------
    // phase current tables
    // ----------------------------------------------------------------
    stsq_pkg::stsq_top_st_t s_reg;
    stsq_pkg::stsq_top_st_t s_next;
    logic [7:0] lut_u;
    logic [7:0] lut_v;
    logic [7:0] lut_w;

    stsq_phase_lut #(.OFS(stsq_pkg::OFS_U)) u_lut_u (
        .pos(s_reg.pos),
        .rect(md.rect),
        .pct(lut_u)
    );
    stsq_phase_lut #(.OFS(stsq_pkg::OFS_V)) u_lut_v (
        .pos(s_reg.pos),
        .rect(md.rect),
        .pct(lut_v)
    );
    stsq_phase_lut #(.OFS(stsq_pkg::OFS_W)) u_lut_w (
        .pos(s_reg.pos),
        .rect(md.rect),
        .pct(lut_w)
    );

    // ----------------------------------------------------------------
    // step events
    // ----------------------------------------------------------------
    logic rise;
    logic fall;
    logic go;
    logic dir_now;
    logic [31:0] status;

    assign rise = f[stsq_pkg::IX_STEP] && !s_reg.step_d;
    assign fall = !f[stsq_pkg::IX_STEP] && s_reg.step_d;
    // direction sampled on a rising edge; a falling edge reuses it
    assign dir_now = rise ? f[stsq_pkg::IX_DIR] : s_reg.dir_lat;
    // falls count only in dual-edge mode and never before a resume
    assign go = s_reg.cp_done && f[stsq_pkg::IX_RESET_N]
        && f[stsq_pkg::IX_FREEZE_N] && md.valid
        && (rise || (fall && md.both && !s_reg.resume_wait));

    assign status = {19'h00000, s_reg.gate, md.valid, !f[stsq_pkg::IX_FREEZE_N],
                     s_reg.cp_done, s_reg.dir_lat, 2'b00, s_reg.pos};

    // ----------------------------------------------------------------
    // next-state logic
    // ----------------------------------------------------------------
    logic [6:0] sum_cw;
    logic [6:0] sum_ccw;
    logic wrap;
    logic [5:0] pos_new;

    always_comb begin
        s_next = s_reg;
        sum_cw = {1'b0, s_reg.pos} + {1'b0, md.inc};
        sum_ccw = {1'b0, s_reg.pos} + stsq_pkg::POS_STEPS - {1'b0, md.inc};
        wrap = 1'b0;
        pos_new = s_reg.pos;
        // position arithmetic modulo 48; mode only sets the stride
        if (dir_now) begin
            wrap = (sum_cw >= stsq_pkg::POS_STEPS);
            pos_new = wrap ? 6'(sum_cw - stsq_pkg::POS_STEPS) : sum_cw[5:0];
        end else begin
            wrap = (s_reg.pos < md.inc);
            pos_new = wrap ? sum_ccw[5:0] : 6'(s_reg.pos - md.inc);
        end
        s_next.step_d = f[stsq_pkg::IX_STEP];
        s_next.cp_run = f[stsq_pkg::IX_RESET_N];
        if (s_reg.mon_cnt != 8'h00) begin
            s_next.mon_cnt = s_reg.mon_cnt - 8'h01;
        end
        if (!f[stsq_pkg::IX_RESET_N]) begin
            s_next.pos = stsq_pkg::POS_RESET;
            s_next.cp_cnt = 20'h00000;
            s_next.cp_done = 1'b0;
            s_next.resume_wait = 1'b0;
            s_next.dir_lat = f[stsq_pkg::IX_DIR];
        end else begin
            // charge-pump start interval counted from release
            if (!s_reg.cp_done) begin
                if (s_reg.cp_cnt == 20'(CP_START_CYC - 1)) begin
                    s_next.cp_done = 1'b1;
                end else begin
                    s_next.cp_cnt = s_reg.cp_cnt + 20'h00001;
                end
            end
            if (!f[stsq_pkg::IX_FREEZE_N]) begin
                s_next.resume_wait = 1'b1;
            end else if (rise) begin
                s_next.resume_wait = 1'b0;
            end
            if (rise) begin
                s_next.dir_lat = f[stsq_pkg::IX_DIR];
            end
            if (go) begin
                s_next.pos = pos_new;
                if (wrap) begin
                    s_next.mon_cnt = 8'(stsq_pkg::MON_CYC);
                    s_next.cyc_cnt = s_reg.cyc_cnt + 16'h0001;
                end
            end
        end
        s_next.mon = (s_next.mon_cnt != 8'h00);
        // currents follow position one clock later
        s_next.ph_u = lut_u;
        s_next.ph_v = lut_v;
        s_next.ph_w = lut_w;
        // gates drop on enable low regardless of the step clock
        s_next.gate = s_reg.cp_done && f[stsq_pkg::IX_RESET_N]
            && f[stsq_pkg::IX_OE] && s_reg.soft_en;
        // apb: one wait state, then pready for a single cycle
        s_next.pready = 1'b0;
        s_next.pslverr = 1'b0;
        if (PSEL && PENABLE && !s_reg.pready) begin
            s_next.pready = 1'b1;
            unique case (PADDR)
                stsq_pkg::ADDR_CTRL: s_next.prdata = {31'h00000000, s_reg.soft_en};
                stsq_pkg::ADDR_STATUS: s_next.prdata = status;
                stsq_pkg::ADDR_CYCLES: s_next.prdata = {16'h0000, s_reg.cyc_cnt};
                default: begin
                    s_next.prdata = 32'h00000000;
                    s_next.pslverr = 1'b1;
                end
            endcase
        end
        if (PSEL && PENABLE && s_reg.pready && PWRITE && PADDR == stsq_pkg::ADDR_CTRL) begin
            s_next.soft_en = PWDATA[stsq_pkg::CTRL_SOFT_EN_BIT];
        end
    end

    // ----------------------------------------------------------------
    // state register
    // ----------------------------------------------------------------
    always_ff @(posedge CORE_CLK) begin
        if (RST) begin
            s_reg <= '0;
            s_reg.soft_en <= stsq_pkg::CTRL_RESET;
        end else begin
            s_reg <= s_next;
        end
    end

    assign PREADY = s_reg.pready;
    assign PRDATA = s_reg.prdata;
    assign PSLVERR = s_reg.pslverr;
    assign PHASE_U = s_reg.ph_u;
    assign PHASE_V = s_reg.ph_v;
    assign PHASE_W = s_reg.ph_w;
    assign GATE_EN = s_reg.gate;
    assign CHARGE_PUMP_RUN = s_reg.cp_run;
    assign CYCLE_MONITOR_PULSE = s_reg.mon;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (RST);

    pump_stop_a: assert property (
        !f[stsq_pkg::IX_RESET_N] |=> !CHARGE_PUMP_RUN && !GATE_EN ##1 !s_reg.cp_done)
        else $error("charge pump or gate active during pin reset");

    start_hold_a: assert property (
        !s_reg.cp_done |=> !GATE_EN && $stable(s_reg.pos))
        else $error("output active before charge-pump start ends");

    init_sine_a: assert property (
        s_reg.pos == stsq_pkg::POS_RESET && !md.rect
        |=> PHASE_U == 8'h00 && PHASE_V == 8'hA9 && PHASE_W == 8'h57)
        else $error("reset position currents not 0/-87/+87");

    init_rect_a: assert property (
        s_reg.pos == stsq_pkg::POS_RESET && md.rect
        |=> PHASE_U == 8'h00 && PHASE_V == 8'h9C && PHASE_W == 8'h64)
        else $error("rectangular reset currents not 0/-100/+100");

    rise_only_a: assert property (
        fall && !md.both && f[stsq_pkg::IX_RESET_N] |=> $stable(s_reg.pos))
        else $error("falling edge stepped in rising-only mode");

    both_edge_a: assert property (
        go && md.inc != 6'h00 |=> s_reg.pos != $past(s_reg.pos))
        else $error("accepted step edge did not move position");

    freeze_hold_a: assert property (
        !f[stsq_pkg::IX_FREEZE_N] && f[stsq_pkg::IX_RESET_N] |=> $stable(s_reg.pos))
        else $error("position moved while frozen");

    resume_rise_a: assert property (
        s_reg.resume_wait && !rise && f[stsq_pkg::IX_RESET_N] |=> $stable(s_reg.pos))
        else $error("resumed before a rising step edge");

    dir_sample_a: assert property (
        !rise && f[stsq_pkg::IX_RESET_N] |=> $stable(s_reg.dir_lat))
        else $error("direction changed away from a rising edge");

    gate_cut_a: assert property (
        !f[stsq_pkg::IX_OE] |=> !GATE_EN)
        else $error("gate drive on with output enable low");

    monitor_pulse_a: assert property (
        go && wrap |=> CYCLE_MONITOR_PULSE [*8])
        else $error("no monitor pulse on cycle wrap");

    mode_keep_a: assert property (
        !go && f[stsq_pkg::IX_RESET_N] |=> $stable(s_reg.pos))
        else $error("position moved without a step edge");
endmodule

// File: stsq_ctrl_model.sv
// stsq_ctrl_model: behavioural motion controller that drives the sequencer pins.
// assumes the bench calls its tasks; pins change by nba just after a clk edge.
`timescale 1ns/100ps
module stsq_ctrl_model (
    input wire logic clk,
    output logic [8:0] pins
);
    // ----------------------------------------------------------------
    // pacing
    // ----------------------------------------------------------------
    localparam int LVL_CYC = 2550; // over 10 us per level and past the pin filter
    localparam int SETTLE_CYC = 1300;

    // idle: step low, modes 0,0,1, rect off, no freeze, cw, enabled, out of reset
    initial pins = 9'h1F8;

    // one pin change, then hold it
    task automatic set(input int ix, input logic v, input int hold);
        @(posedge clk);
        pins[ix] <= v;
        repeat (hold) @(posedge clk);
    endtask

    // even duty, so dual-edge steps come out of equal width
    task automatic period();
        set(stsq_pkg::IX_STEP, 1'b1, LVL_CYC);
        set(stsq_pkg::IX_STEP, 1'b0, LVL_CYC);
    endtask

    // mode pins move only while step is low, then the filter is waited out
    task automatic mode(input logic a, input logic b, input logic e, input logic rn);
        @(posedge clk);
        pins[4:1] <= {rn, e, b, a};
        repeat (SETTLE_CYC) @(posedge clk);
    endtask

    // misbehaves on purpose: steps on the very edge that leaves reset
    task automatic wake_with_step();
        @(posedge clk);
        pins[stsq_pkg::IX_RESET_N] <= 1'b1;
        pins[stsq_pkg::IX_STEP] <= 1'b1;
        repeat (LVL_CYC) @(posedge clk);
        set(stsq_pkg::IX_STEP, 1'b0, LVL_CYC);
    endtask
endmodule

// File: three_phase_step_sequencer_tb.sv
// three_phase_step_sequencer_tb: self-checking bench for the step sequencer.
// assumes stsq_ctrl_model drives the pins and this bench is the apb master.
`timescale 1ns/100ps
module three_phase_step_sequencer_tb;
    logic clk, rst, psel, penable, pwrite, pready, pslverr, gate_en, cp_run, mon, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [7:0] ph_u, ph_v, ph_w;
    logic [8:0] pins;
    logic [2:0] md [8] = '{3'b001, 3'b011, 3'b101, 3'b111, 3'b000, 3'b010, 3'b100, 3'b110};
    int dl [8] = '{8, 4, 2, 1, 8, 4, 2, 0};
    int miscompares = 0;
    int checks = 0;
    int mon_hi = 0;
    int exp_pos;

    // short start count keeps the run brief
    stsq_sequencer #(.CP_START_CYC(50)) u_stsq_sequencer (
        .CORE_CLK(clk), .RST(rst), .STEP_CLK(pins[stsq_pkg::IX_STEP]),
        .MODE_A(pins[stsq_pkg::IX_MODE_A]), .MODE_B(pins[stsq_pkg::IX_MODE_B]),
        .EDGE_MODE(pins[stsq_pkg::IX_EDGE]), .RECT_CURRENT_SELECT_N(pins[stsq_pkg::IX_RECT_N]),
        .FREEZE_N(pins[stsq_pkg::IX_FREEZE_N]), .ROTATION_DIRECTION(pins[stsq_pkg::IX_DIR]),
        .OUTPUT_ENABLE(pins[stsq_pkg::IX_OE]), .RESET_N(pins[stsq_pkg::IX_RESET_N]),
        .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr), .PHASE_U(ph_u), .PHASE_V(ph_v),
        .PHASE_W(ph_w), .GATE_EN(gate_en), .CHARGE_PUMP_RUN(cp_run), .CYCLE_MONITOR_PULSE(mon));

    stsq_ctrl_model u_stsq_ctrl_model (.clk(clk), .pins(pins));

    // ----------------------------------------------------------------
    // clock, monitor width, watchdog
    // ----------------------------------------------------------------
    always #2 clk = ~clk;

    // total high time of the monitor pulse
    always @(posedge clk) begin
        if (mon === 1'b1) mon_hi <= mon_hi + 1;
    end

    // the tests need about 91700 cycles; a small margin keeps a hang short
    initial begin
        repeat (98000) @(posedge clk);
        miscompares++;
        close_out();
    end

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask

    // one apb transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1);
        chk("apb_wait", n, 32'h2);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic pos_is(input int e);
        apb(1'b0, stsq_pkg::ADDR_STATUS, 32'h0);
        chk("position", {26'h0, rd[5:0]}, e);
    endtask

    task automatic phases(input logic [7:0] u, input logic [7:0] v, input logic [7:0] w);
        chk("phase_u", {24'h0, ph_u}, {24'h0, u});
        chk("phase_v", {24'h0, ph_v}, {24'h0, v});
        chk("phase_w", {24'h0, ph_w}, {24'h0, w});
    endtask

    task automatic close_out();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    initial begin
        clk = 1'b0;
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        repeat (100) @(posedge clk);
        phases(8'h00, 8'hA9, 8'h57);
        chk("pump", {31'h0, cp_run}, 32'h1);
        chk("gate", {31'h0, gate_en}, 32'h1);
        apb(1'b0, stsq_pkg::ADDR_CTRL, 32'h0);
        chk("ctrl", rd, 32'h1);
        apb(1'b1, stsq_pkg::ADDR_STATUS, 32'hFFFF_FFFF);
        pos_is(0);
        apb(1'b0, 12'h00C, 32'h0);
        chk("unmapped_err", {31'h0, err}, 32'h1);
        chk("unmapped_data", rd, 32'h0);
        $display("test reset finished");
        u_stsq_ctrl_model.mode(1'b0, 1'b1, 1'b1, 1'b0);
        phases(8'h00, 8'h9C, 8'h64);
        u_stsq_ctrl_model.mode(1'b0, 1'b0, 1'b1, 1'b1);
        phases(8'h00, 8'hA9, 8'h57);
        $display("test rect finished");
        // gating through the pin and through the soft enable
        u_stsq_ctrl_model.set(stsq_pkg::IX_OE, 1'b0, 1300);
        chk("gate", {31'h0, gate_en}, 32'h0);
        u_stsq_ctrl_model.set(stsq_pkg::IX_OE, 1'b1, 1300);
        chk("gate", {31'h0, gate_en}, 32'h1);
        apb(1'b1, stsq_pkg::ADDR_CTRL, 32'h0);
        repeat (3) @(posedge clk);
        chk("gate", {31'h0, gate_en}, 32'h0);
        apb(1'b1, stsq_pkg::ADDR_CTRL, 32'h1);
        repeat (3) @(posedge clk);
        chk("gate", {31'h0, gate_en}, 32'h1);
        $display("test enable finished");
        u_stsq_ctrl_model.set(stsq_pkg::IX_RESET_N, 1'b0, 2550);
        chk("pump", {31'h0, cp_run}, 32'h0);
        chk("gate", {31'h0, gate_en}, 32'h0);
        u_stsq_ctrl_model.wake_with_step();
        pos_is(0);
        chk("gate", {31'h0, gate_en}, 32'h1);
        u_stsq_ctrl_model.set(stsq_pkg::IX_STEP, 1'b1, 500);
        u_stsq_ctrl_model.set(stsq_pkg::IX_STEP, 1'b0, 1300);
        pos_is(0);
        $display("test reset pin finished");
        u_stsq_ctrl_model.set(stsq_pkg::IX_FREEZE_N, 1'b0, 1300);
        u_stsq_ctrl_model.period();
        pos_is(0);
        phases(8'h00, 8'hA9, 8'h57);
        u_stsq_ctrl_model.set(stsq_pkg::IX_FREEZE_N, 1'b1, 1300);
        u_stsq_ctrl_model.period();
        pos_is(8);
        $display("test freeze finished");
        // counter-clockwise steps back through the wrap
        u_stsq_ctrl_model.set(stsq_pkg::IX_DIR, 1'b0, 1300);
        u_stsq_ctrl_model.period();
        pos_is(0);
        u_stsq_ctrl_model.period();
        pos_is(40);
        apb(1'b0, stsq_pkg::ADDR_CYCLES, 32'h0);
        chk("cycles", rd, 32'h1);
        u_stsq_ctrl_model.set(stsq_pkg::IX_DIR, 1'b1, 1300);
        $display("test direction finished");
        // every mode, illegal one last; position carries over each change
        exp_pos = 40;
        for (int i = 0; i < 8; i++) begin
            u_stsq_ctrl_model.mode(md[i][2], md[i][1], md[i][0], 1'b1);
            u_stsq_ctrl_model.period();
            exp_pos = (exp_pos + dl[i]) % 48;
            pos_is(exp_pos);
        end
        apb(1'b0, stsq_pkg::ADDR_CYCLES, 32'h0);
        chk("cycles", rd, 32'h2);
        chk("monitor_high", mon_hi, 2 * stsq_pkg::MON_CYC);
        $display("test modes finished");
        close_out();
    end
endmodule
